// file: limit_stats_defs.svh
// Constants for the limit and table statistics unit
// Behaviour
// - Upper clamp enabled: write operand if not above bound, else write bound.
// - Upper clamp condition high only when enabled and operand above bound; disabled writes nothing.
// - Lower clamp enabled: write operand if at least bound, else write bound.
// - Lower clamp condition high only when enabled and operand below bound; disabled writes nothing.
// - Every data word is a 16-bit two's-complement signed integer.
// - Maximum: scan table, store largest value, then its position in next word.
// - Equal maxima report the lowest position.
// - Minimum: scan table, store smallest value, then its position in next word.
// - Equal minima report the lowest position.
// - Result into index register stores only the extreme value, no position word.
// - Mean: average of table words stored at the result location.
// - Table length is 1 to 64 words; the unit takes a length of 0 as 1 and a length above 64 as 64.
// - Table operations: condition follows enable; disabled means no execution.
`ifndef LIMIT_STATS_DEFS_SVH
`define LIMIT_STATS_DEFS_SVH
`define LS_WORD_W 16
`define LS_LEN_MIN 7'h01
`define LS_LEN_MAX 7'h40
`define LS_SUM_W 22
`endif

// file: limit_stats_pkg.sv
// Types shared by the limit and table statistics unit
package limit_stats_pkg;
    typedef enum logic [2:0] {
        OP_UPPER = 3'h0,
        OP_LOWER = 3'h1,
        OP_MAX = 3'h2,
        OP_MIN = 3'h3,
        OP_MEAN = 3'h4
    } op_t;
    typedef struct packed {
        op_t op;
        logic enable;
        logic signed [15:0] operand;
        logic signed [15:0] bound;
        logic [6:0] length;
        logic toIndex;
    } cmd_t;
    typedef struct packed {
        logic valid;
        logic cond;
        logic write0;
        logic signed [15:0] data0;
        logic write1;
        logic [15:0] data1;
    } result_t;
endpackage

// file: mean_divider.sv
// Restoring divider for the table mean, truncating toward zero
`timescale 1ns/100ps
`include "limit_stats_defs.svh"
module mean_divider import limit_stats_pkg::*; #(
    parameter int SUM_W = `LS_SUM_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Request
    input wire logic start,
    input wire logic signed [SUM_W-1:0] sum,
    input wire logic [6:0] divisor,
    // Answer
    output logic done,
    output logic signed [15:0] quotient
);
    logic [SUM_W-1:0] mag_r, mag_nxt;
    logic [SUM_W-1:0] rem_r, rem_nxt;
    logic [4:0] cnt_r;
    logic neg_r, busy_r;
    logic [6:0] div_r;
    wire [SUM_W-1:0] absSum = sum[SUM_W-1] ? SUM_W'(-sum) : SUM_W'(sum);
    wire [SUM_W-1:0] shifted = {rem_r[SUM_W-2:0], mag_r[SUM_W-1]};
    wire fits = shifted >= SUM_W'(div_r);
    wire [SUM_W-1:0] mag0 = {mag_r[SUM_W-2:0], fits};
    wire [15:0] magQ = mag0[15:0];
    assign rem_nxt = fits ? shifted - SUM_W'(div_r) : shifted;
    assign mag_nxt = mag0;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mag_r <= '0;
            rem_r <= '0;
            cnt_r <= 5'h00;
            neg_r <= 1'b0;
            busy_r <= 1'b0;
            div_r <= 7'h01;
            done <= 1'b0;
            quotient <= 16'h0000;
        end else begin
            done <= 1'b0;
            if (start) begin
                mag_r <= absSum;
                rem_r <= '0;
                cnt_r <= 5'(SUM_W - 1);
                neg_r <= sum[SUM_W-1];
                div_r <= divisor;
                busy_r <= 1'b1;
            end else if (busy_r) begin
                mag_r <= mag_nxt;
                rem_r <= rem_nxt;
                cnt_r <= cnt_r - 5'h01;
                if (cnt_r == 5'h00) begin
                    busy_r <= 1'b0;
                    done <= 1'b1;
                    // Magnitude of a 16-bit mean always fits 16 bits
                    quotient <= neg_r ? 16'(-magQ) : magQ;
                end
            end
        end
    end
endmodule

// file: limit_stats_unit.sv
// Signed clamp and table statistics unit
`timescale 1ns/100ps
`include "limit_stats_defs.svh"
module limit_stats_unit import limit_stats_pkg::*; #(
    parameter int MAX_LEN = `LS_LEN_MAX,
    parameter int SUM_W = `LS_SUM_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Command
    input wire logic start,
    input wire cmd_t cmd,
    // Table words, one per cycle while scanning
    output logic tabReq,
    output logic [6:0] tabIndex,
    input wire logic tabValid,
    input wire logic signed [15:0] tabWord,
    // Result
    output result_t res,
    output logic busy
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SCAN = 2'b01,
        ST_DIV = 2'b11
    } state_t;

    state_t state_r, state_nxt;
    logic signed [15:0] best_r;
    logic [6:0] bestPos_r, pos_r, len_r;
    logic signed [SUM_W-1:0] sum_r;
    op_t op_r;
    logic toIndex_r;
    logic divStart_r;
    logic divDone;
    logic signed [15:0] divQ;

    // Signed compare helpers; strict so equal entries keep the lower position
    function automatic logic beats(input op_t op, input logic signed [15:0] a,
                                   input logic signed [15:0] b);
        beats = (op == OP_MAX) ? (a > b) : (a < b);
    endfunction

    wire isTable = cmd.op == OP_MAX || cmd.op == OP_MIN || cmd.op == OP_MEAN;
    wire launch = start && state_r == ST_IDLE;
    wire upAbove = cmd.operand > cmd.bound;
    wire lowBelow = cmd.operand < cmd.bound;
    wire lastWord = (pos_r + 7'h01) == len_r;
    wire take = state_r == ST_SCAN && tabValid;
    wire takeBetter = pos_r == 7'h00 || beats(op_r, tabWord, best_r);
    wire [6:0] clampLen = (cmd.length == 7'h00) ? `LS_LEN_MIN :
        (cmd.length > 7'(MAX_LEN)) ? 7'(MAX_LEN) : cmd.length;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (launch && cmd.enable && isTable) begin
                    state_nxt = ST_SCAN;
                end
            end
            ST_SCAN: begin
                if (take && lastWord) begin
                    state_nxt = (op_r == OP_MEAN) ? ST_DIV : ST_IDLE;
                end
            end
            ST_DIV: begin
                if (divDone) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
            best_r <= 16'h0000;
            bestPos_r <= 7'h00;
            pos_r <= 7'h00;
            len_r <= `LS_LEN_MIN;
            sum_r <= '0;
            op_r <= OP_UPPER;
            toIndex_r <= 1'b0;
            divStart_r <= 1'b0;
            res <= '0;
            tabReq <= 1'b0;
            tabIndex <= 7'h00;
            busy <= 1'b0;
        end else begin
            state_r <= state_nxt;
            res <= '0;
            divStart_r <= 1'b0;
            busy <= state_nxt != ST_IDLE;
            tabReq <= state_nxt == ST_SCAN;
            if (launch) begin
                op_r <= cmd.op;
                toIndex_r <= cmd.toIndex;
                len_r <= clampLen;
                pos_r <= 7'h00;
                tabIndex <= 7'h00;
                sum_r <= '0;
                case (cmd.op)
                    OP_UPPER: begin
                        res.valid <= 1'b1;
                        res.write0 <= cmd.enable;
                        res.data0 <= upAbove ? cmd.bound : cmd.operand;
                        res.cond <= cmd.enable && upAbove;
                    end
                    OP_LOWER: begin
                        res.valid <= 1'b1;
                        res.write0 <= cmd.enable;
                        res.data0 <= lowBelow ? cmd.bound : cmd.operand;
                        res.cond <= cmd.enable && lowBelow;
                    end
                    default: begin
                        // Disabled table op: report off, no execution
                        res.valid <= !cmd.enable;
                    end
                endcase
            end
            if (take) begin
                pos_r <= pos_r + 7'h01;
                tabIndex <= pos_r + 7'h01;
                sum_r <= sum_r + SUM_W'(tabWord);
                if (takeBetter) begin
                    best_r <= tabWord;
                    bestPos_r <= pos_r;
                end
                if (lastWord && op_r == OP_MEAN) begin
                    divStart_r <= 1'b1;
                end else if (lastWord) begin
                    res.valid <= 1'b1;
                    res.cond <= 1'b1;
                    res.write0 <= 1'b1;
                    res.data0 <= takeBetter ? tabWord : best_r;
                    res.write1 <= !toIndex_r;
                    res.data1 <= {9'h000, takeBetter ? pos_r : bestPos_r};
                end
            end
            if (divDone) begin
                res.valid <= 1'b1;
                res.cond <= 1'b1;
                res.write0 <= 1'b1;
                res.data0 <= divQ;
            end
        end
    end

    mean_divider #(.SUM_W(SUM_W)) mean_divider_inst (
        .clock(clock),
        .rst_b(rst_b),
        .start(divStart_r),
        .sum(sum_r),
        .divisor(len_r),
        .done(divDone),
        .quotient(divQ)
    );

    // Clamp results are checked one cycle after the command is taken
    chk_upper_clamp: assert property (@(posedge clock) disable iff (!rst_b)
        launch && cmd.op == OP_UPPER && cmd.enable |=> res.valid && res.write0
        && res.cond == ($past(cmd.operand) > $past(cmd.bound))
        && res.data0 == (res.cond ? $past(cmd.bound) : $past(cmd.operand)))
        else $error("upper clamp result wrong");

    chk_upper_off: assert property (@(posedge clock) disable iff (!rst_b)
        launch && cmd.op == OP_UPPER && !cmd.enable
        |=> res.valid && !res.write0 && !res.cond)
        else $error("disabled upper clamp wrote");

    chk_lower_clamp: assert property (@(posedge clock) disable iff (!rst_b)
        launch && cmd.op == OP_LOWER && cmd.enable |=> res.valid && res.write0
        && res.cond == ($past(cmd.operand) < $past(cmd.bound))
        && res.data0 == (res.cond ? $past(cmd.bound) : $past(cmd.operand)))
        else $error("lower clamp result wrong");

    chk_lower_off: assert property (@(posedge clock) disable iff (!rst_b)
        launch && cmd.op == OP_LOWER && !cmd.enable
        |=> res.valid && !res.write0 && !res.cond)
        else $error("disabled lower clamp wrote");

    chk_index_drop: assert property (@(posedge clock) disable iff (!rst_b)
        res.write1 |-> !toIndex_r && (op_r == OP_MAX || op_r == OP_MIN))
        else $error("position written to index");

    chk_table_off: assert property (@(posedge clock) disable iff (!rst_b)
        launch && isTable && !cmd.enable |=> res.valid && !res.cond && !res.write0 && !busy)
        else $error("disabled table op ran");

    chk_scan_len: assert property (@(posedge clock) disable iff (!rst_b)
        state_r == ST_SCAN |-> pos_r < len_r && len_r <= 7'(MAX_LEN) && len_r != 7'h00)
        else $error("scan position out of range");

    chk_pos_range: assert property (@(posedge clock) disable iff (!rst_b)
        res.write1 |-> res.data1 < {9'h000, len_r})
        else $error("reported position beyond table");

    // Running extreme never loses to a word already taken
    chk_max_track: assert property (@(posedge clock) disable iff (!rst_b)
        take && op_r == OP_MAX |=> best_r >= $past(tabWord))
        else $error("maximum lost a larger word");

    chk_min_track: assert property (@(posedge clock) disable iff (!rst_b)
        take && op_r == OP_MIN |=> best_r <= $past(tabWord))
        else $error("minimum lost a smaller word");

    chk_tie_keep: assert property (@(posedge clock) disable iff (!rst_b)
        take && pos_r != 7'h00 && tabWord == best_r |=> bestPos_r == $past(bestPos_r))
        else $error("equal extreme moved the position");

    chk_first_word: assert property (@(posedge clock) disable iff (!rst_b)
        take && pos_r == 7'h00 |=> bestPos_r == 7'h00 && best_r == $past(tabWord))
        else $error("first table word not taken");

    chk_table_done: assert property (@(posedge clock) disable iff (!rst_b)
        take && lastWord && op_r != OP_MEAN |=> res.valid && res.cond && res.write0 && !busy)
        else $error("table result missing");

    // Divider needs SUM_W steps; the window only suits sums up to about 39 bits
    chk_mean_time: assert property (@(posedge clock) disable iff (!rst_b)
        divStart_r |-> ##[1:40] divDone)
        else $error("mean never finished");

    chk_mean_result: assert property (@(posedge clock) disable iff (!rst_b)
        divDone |=> res.valid && res.cond && res.write0 && !res.write1
        && res.data0 == $past(divQ))
        else $error("mean result not reported");
endmodule

// file: test_limit_stats_unit.sv
// Self-checking bench for the clamp and table statistics unit
`timescale 1ns/100ps
`define CHECK(g, e) begin checked++; if ((g) !== (e)) begin errorCnt++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module test_limit_stats_unit import limit_stats_pkg::*;;
    logic clock, rst_b, start, tabValid, tabReq, busy;
    cmd_t cmd;
    logic signed [15:0] tabWord;
    logic [6:0] tabIndex;
    result_t res, got;
    logic signed [15:0] tbl [0:63];
    int errorCnt = 0;
    int checked = 0;

    // Table memory answers every request at once
    assign tabValid = tabReq;
    assign tabWord = tbl[tabIndex[5:0]];

    limit_stats_unit limit_stats_unit_inst (
        .clock(clock), .rst_b(rst_b), .start(start), .cmd(cmd), .tabReq(tabReq),
        .tabIndex(tabIndex), .tabValid(tabValid), .tabWord(tabWord), .res(res), .busy(busy));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, errorCnt);
        if (errorCnt == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Entered 1 ns after an edge; leaves at the same phase
    task automatic run(input op_t op, input logic en, input logic signed [15:0] a,
                       input logic signed [15:0] b, input logic [6:0] len, input logic toIdx);
        int n;
        n = 0;
        cmd = '{op: op, enable: en, operand: a, bound: b, length: len, toIndex: toIdx};
        start = 1'b1;
        @(posedge clock);
        #1;
        start = 1'b0;
        `CHECK(busy, en && (op == OP_MAX || op == OP_MIN || op == OP_MEAN))
        while (res.valid !== 1'b1 && n < 200) begin
            @(posedge clock);
            #1;
            n++;
        end
        got = res;
        `CHECK(got.valid, 1'b1)
        `CHECK(busy, 1'b0)
        @(posedge clock);
        #1;
    endtask

    task automatic test_clamp();
        logic signed [15:0] av [0:5] = '{16'sh0bb8, 16'sh1194, 16'sh0fa0, 16'sh8000,
                                         16'sh7fff, 16'shfc18};
        logic signed [15:0] bv [0:5] = '{16'sh0fa0, 16'sh0fa0, 16'sh0fa0, 16'sh7fff,
                                         16'sh8000, 16'shf8f8};
        logic lower, en, lim;
        for (int i = 0; i < 6; i++) begin
            for (int k = 0; k < 4; k++) begin
                lower = k[0];
                en = k[1];
                lim = lower ? (av[i] < bv[i]) : (av[i] > bv[i]);
                run(lower ? OP_LOWER : OP_UPPER, en, av[i], bv[i], 7'h01, 1'b0);
                `CHECK(got.write0, en)
                `CHECK(got.cond, en & lim)
                `CHECK(got.write1, 1'b0)
                if (en) begin
                    `CHECK(got.data0, lim ? bv[i] : av[i])
                end
            end
        end
        $display("clamp test done");
    endtask

    task automatic test_stats(input op_t op, input logic [6:0] len, input logic toIdx);
        logic signed [15:0] best;
        logic [15:0] pos;
        int sum;
        best = tbl[0];
        pos = 16'h0000;
        sum = 0;
        for (int i = 0; i < int'(len); i++) begin
            sum += tbl[i];
            // Strict compare keeps the first of equal extremes
            if ((op == OP_MAX && tbl[i] > best) || (op == OP_MIN && tbl[i] < best)) begin
                best = tbl[i];
                pos = 16'(i);
            end
        end
        run(op, 1'b1, 16'sh0000, 16'sh0000, len, toIdx);
        `CHECK(got.cond, 1'b1)
        `CHECK(got.write0, 1'b1)
        if (op == OP_MEAN) begin
            `CHECK(got.data0, 16'(sum / int'(len)))
            `CHECK(got.write1, 1'b0)
        end else begin
            `CHECK(got.data0, best)
            `CHECK(got.data1, pos)
            `CHECK(got.write1, !toIdx)
        end
        $display("table test done op %0d len %0d", op, len);
    endtask

    task automatic test_disabled();
        for (int k = 2; k < 5; k++) begin
            run(op_t'(k), 1'b0, 16'sh0000, 16'sh0000, 7'h0a, 1'b0);
            `CHECK(got.cond, 1'b0)
            `CHECK(got.write0, 1'b0)
            `CHECK(got.write1, 1'b0)
        end
        $display("disabled table test done");
    endtask

    initial begin
        rst_b = 1'b0;
        start = 1'b0;
        cmd = '0;
        for (int i = 0; i < 64; i++) begin
            tbl[i] = 16'(i * 523 - 16000);
        end
        tbl[3] = 16'sh7fff;
        tbl[7] = 16'sh7fff;
        tbl[2] = 16'sh8000;
        tbl[5] = 16'sh8000;
        repeat (5) @(posedge clock);
        #1;
        rst_b = 1'b1;
        @(posedge clock);
        #1;
        test_clamp();
        for (int k = 2; k < 5; k++) begin
            test_stats(op_t'(k), 7'h01, 1'b0);
            test_stats(op_t'(k), 7'h0a, 1'b0);
            test_stats(op_t'(k), 7'h40, 1'b0);
        end
        test_stats(OP_MAX, 7'h0a, 1'b1);
        test_stats(OP_MIN, 7'h0a, 1'b1);
        test_disabled();
        for (int i = 0; i < 64; i++) begin
            tbl[i] = 16'sh8000;
        end
        test_stats(OP_MEAN, 7'h40, 1'b0);
        test_stats(OP_MIN, 7'h40, 1'b0);
        tbl[0] = 16'shffff;
        tbl[1] = 16'shfffe;
        test_stats(OP_MEAN, 7'h02, 1'b0);
        give_verdict();
    end

    // Whole run needs about six hundred cycles
    initial begin
        #(20000 * 5);
        errorCnt++;
        give_verdict();
    end
endmodule
